//--- lepr_defines.svh
/*
 * Register offsets, field positions, reset values and sizes of the LED
 * program register bank.
 * Assumes inclusion by bare name from the package and the design module.
 */
`ifndef LEPR_DEFINES_SVH
`define LEPR_DEFINES_SVH

// ==========================================================================
// register offsets
`define LEPR_ADDR_DUTY_FIRST     8'h16
`define LEPR_ADDR_DUTY_LAST      8'h1E
`define LEPR_ADDR_GROUP_ONE      8'h48
`define LEPR_ADDR_GROUP_TWO      8'h49
`define LEPR_ADDR_GROUP_THREE    8'h4A
`define LEPR_ADDR_ENG_ONE_START  8'h4C
`define LEPR_ADDR_ENG_TWO_START  8'h4D
`define LEPR_ADDR_ENG_THREE_START 8'h4E
`define LEPR_ADDR_WINDOW_SEL     8'h4F
`define LEPR_ADDR_ENG_ONE_HIGH   8'h70
`define LEPR_ADDR_ENG_ONE_LOW    8'h71

// ==========================================================================
// fields, reset values and sizes
`define LEPR_BYTE_RESET          8'h00
`define LEPR_START_RESET         7'h00
`define LEPR_WINDOW_RESET        3'h0
`define LEPR_START_MSB           6
`define LEPR_WINDOW_MSB          2
`define LEPR_AUX_BIT             7
`define LEPR_NINE_BIT            0
`define LEPR_LED_COUNT           9
`define LEPR_WINDOW_LAST         3'h5
`define LEPR_MAP_RESET           9'h000
`define LEPR_NO_GROUP            2'h0
`define LEPR_GROUP_ONE           2'h1
`define LEPR_GROUP_TWO           2'h2
`define LEPR_GROUP_THREE         2'h3

`endif

//--- lepr_pkg.sv
/*
 * Types of the LED program register bank.
 * Assumes lepr_defines.svh sits in the same folder.
 */
`include "lepr_defines.svh"

package lepr_pkg;

	// ======================================================================
	// register access from the serial control interface
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} lepr_reg_req_t;

	// ======================================================================
	// program memory access from the serial control interface
	typedef struct packed {
		logic       valid;
		logic [3:0] offset;
	} lepr_prog_req_t;

	typedef struct packed {
		logic       valid;
		logic       in_range;
		logic [6:0] location;
	} lepr_prog_addr_t;

endpackage : lepr_pkg

//--- lepr_regs.sv
/*
 * LED program register bank: per-LED duty registers, three group dimming
 * scalers, engine start locations, program window selector and the
 * engine-one assignment readback, with the scaled LED levels it produces.
 * Assumes the serial control interface decodes bus frames into one-cycle
 * register and program access strobes synchronous to clk_in.
 * Also assumes LED group assignment and engine-one pin assignment arrive
 * as steady levels from the engines, sampled on every clock.
 */
//
// Behaviour
// - group three has an 8-bit read/write scaler, reset zero, dimming every LED in that group.
// - one write to a group scaler changes all LEDs of that group at once.
// - each LED keeps its own duty register at 0x16 to 0x1E, one write per LED.
// - engine one has a 7-bit read/write start location in bits 6 to 0, reset zero.
// - engine two has a 7-bit read/write start location in bits 6 to 0, reset zero.
// - engine three has a 7-bit read/write start location in bits 6 to 0, reset zero.
// - a 3-bit read/write window selector, reset zero, picks the page for program accesses.
// - program memory is six pages of sixteen instructions, ninety-six in all.
// - window value n selects locations 16n to 16n+15, up to value 101 for 0x50 to 0x5F.
// - bit 7 of the engine-one high register reads one when the aux output belongs to engine one.
// - bit 0 of the engine-one high register reads one when output nine belongs to engine one.
// - bits 7 to 0 of the engine-one low register report outputs eight to one for engine one.
// - all engine-one assignment bits are read-only and reset to zero.
// - groups one and two have 8-bit read/write scalers, each reset zero.
`timescale 1ns/1ps
`include "lepr_defines.svh"

module lepr_regs (
	input  wire logic                      clk_in,
	input  wire logic                      rstn_in,
	input  wire lepr_pkg::lepr_reg_req_t   reg_req_in,
	output logic      [7:0]                reg_rdata_out,
	output logic                           reg_rvalid_out,
	input  wire lepr_pkg::lepr_prog_req_t  prog_req_in,
	output lepr_pkg::lepr_prog_addr_t      prog_addr_out,
	input  wire logic [2:0]                engine_start_in,
	output logic      [2:0][6:0]           engine_fetch_location_out,
	output logic      [2:0]                engine_fetch_valid_out,
	input  wire logic [8:0][1:0]           led_group_in,
	output logic      [8:0][7:0]           led_level_out,
	input  wire logic                      engine_one_aux_output_assigned_in,
	input  wire logic [8:0]                engine_one_outputs_assigned_in
);

	// ======================================================================
	// storage
	logic [8:0][7:0] led_duty;
	logic [7:0]      group_one_dim_scale;
	logic [7:0]      group_two_dim_scale;
	logic [7:0]      group_three_dim_scale;
	logic [2:0][6:0] engine_start_location;
	logic [2:0]      program_window_selector;
	// status copies, loaded from the engines every clock
	logic            engine_one_aux_output_assigned;
	logic [8:0]      engine_one_outputs_assigned;

	// ======================================================================
	// helpers

	// 8x8 product kept in its upper byte, full scale passes full duty
	function automatic logic [7:0] scale_level(input logic [7:0] duty,
		input logic [7:0] scale);
		logic [15:0] product;
		product = 16'(duty) * 16'(scale) + 16'(duty);
		return product[15:8];
	endfunction

	// select the scaler of a group, ungrouped LEDs run at their own duty
	function automatic logic [7:0] group_scale(input logic [1:0] group,
		input logic [7:0] s1, input logic [7:0] s2, input logic [7:0] s3);
		case (group)
			`LEPR_GROUP_ONE:   return s1;
			`LEPR_GROUP_TWO:   return s2;
			`LEPR_GROUP_THREE: return s3;
			default:           return 8'hFF;
		endcase
	endfunction

	// ======================================================================
	// address decode
	wire        wr_en        = reg_req_in.wr;
	wire [7:0]  addr         = reg_req_in.addr;
	wire        hit_duty     = (addr >= `LEPR_ADDR_DUTY_FIRST) &&
		(addr <= `LEPR_ADDR_DUTY_LAST);
	wire [7:0]  duty_diff    = addr - `LEPR_ADDR_DUTY_FIRST;
	wire [3:0]  duty_index   = duty_diff[3:0];
	// write strobes, one per writable register except one shared by all nine duty registers
	wire        wr_duty      = wr_en && hit_duty;
	wire        wr_group_one = wr_en && (addr == `LEPR_ADDR_GROUP_ONE);
	wire        wr_group_two = wr_en && (addr == `LEPR_ADDR_GROUP_TWO);
	wire        wr_group_thr = wr_en && (addr == `LEPR_ADDR_GROUP_THREE);
	wire        wr_start_one = wr_en && (addr == `LEPR_ADDR_ENG_ONE_START);
	wire        wr_start_two = wr_en && (addr == `LEPR_ADDR_ENG_TWO_START);
	wire        wr_start_thr = wr_en && (addr == `LEPR_ADDR_ENG_THREE_START);
	wire        wr_window    = wr_en && (addr == `LEPR_ADDR_WINDOW_SEL);

	// read views of the narrow and read-only registers, unused bits read zero
	wire [7:0]  start_one_view   = {1'b0, engine_start_location[0]};
	wire [7:0]  start_two_view   = {1'b0, engine_start_location[1]};
	wire [7:0]  start_three_view = {1'b0, engine_start_location[2]};
	wire [7:0]  window_view      = {5'h00, program_window_selector};
	wire [7:0]  high_view;
	wire [7:0]  low_view         = engine_one_outputs_assigned[7:0];

	// aux flag and output nine sit at opposite ends of the high byte
	assign high_view[`LEPR_AUX_BIT]  = engine_one_aux_output_assigned;
	assign high_view[`LEPR_NINE_BIT] = engine_one_outputs_assigned[8];
	assign high_view[6:1]            = 6'h00;

	// read mux, unmapped and write-only space reads zero
	logic [7:0] next_rdata;
	always_comb begin
		next_rdata = `LEPR_BYTE_RESET;
		if (hit_duty) begin
			next_rdata = led_duty[duty_index];
		end else begin
			case (addr)
				`LEPR_ADDR_GROUP_ONE:       next_rdata = group_one_dim_scale;
				`LEPR_ADDR_GROUP_TWO:       next_rdata = group_two_dim_scale;
				`LEPR_ADDR_GROUP_THREE:     next_rdata = group_three_dim_scale;
				`LEPR_ADDR_ENG_ONE_START:   next_rdata = start_one_view;
				`LEPR_ADDR_ENG_TWO_START:   next_rdata = start_two_view;
				`LEPR_ADDR_ENG_THREE_START: next_rdata = start_three_view;
				`LEPR_ADDR_WINDOW_SEL:      next_rdata = window_view;
				`LEPR_ADDR_ENG_ONE_HIGH:    next_rdata = high_view;
				`LEPR_ADDR_ENG_ONE_LOW:     next_rdata = low_view;
				default:                    next_rdata = `LEPR_BYTE_RESET;
			endcase
		end
	end

	// ======================================================================
	// register writes, one short process per register or register array

	// per-LED duty registers, indexed by offset from the first one
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			led_duty <= '0;
		end else if (wr_duty) begin
			led_duty[duty_index] <= reg_req_in.wdata;
		end
	end

	// group one scaler
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			group_one_dim_scale <= `LEPR_BYTE_RESET;
		end else if (wr_group_one) begin
			group_one_dim_scale <= reg_req_in.wdata;
		end
	end

	// group two scaler
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			group_two_dim_scale <= `LEPR_BYTE_RESET;
		end else if (wr_group_two) begin
			group_two_dim_scale <= reg_req_in.wdata;
		end
	end

	// group three scaler, one write dims the whole group
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			group_three_dim_scale <= `LEPR_BYTE_RESET;
		end else if (wr_group_thr) begin
			group_three_dim_scale <= reg_req_in.wdata;
		end
	end

	// engine start locations, bit 7 of the byte is not stored
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			engine_start_location <= '0;
		end else begin
			if (wr_start_one)
				engine_start_location[0] <= reg_req_in.wdata[`LEPR_START_MSB:0];
			if (wr_start_two)
				engine_start_location[1] <= reg_req_in.wdata[`LEPR_START_MSB:0];
			if (wr_start_thr)
				engine_start_location[2] <= reg_req_in.wdata[`LEPR_START_MSB:0];
		end
	end

	// program window selector, values six and seven are kept as written
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			program_window_selector <= `LEPR_WINDOW_RESET;
		end else if (wr_window) begin
			program_window_selector <= reg_req_in.wdata[`LEPR_WINDOW_MSB:0];
		end
	end

	// read answer one cycle after the strobe
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			reg_rdata_out  <= `LEPR_BYTE_RESET;
			reg_rvalid_out <= 1'b0;
		end else begin
			reg_rdata_out  <= reg_req_in.rd ? next_rdata : `LEPR_BYTE_RESET;
			reg_rvalid_out <= reg_req_in.rd;
		end
	end

	// ======================================================================
	// engine-one assignment status, read-only, sampled from the engines
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			engine_one_aux_output_assigned <= 1'b0;
			engine_one_outputs_assigned    <= `LEPR_MAP_RESET;
		end else begin
			engine_one_aux_output_assigned <= engine_one_aux_output_assigned_in;
			engine_one_outputs_assigned    <= engine_one_outputs_assigned_in;
		end
	end

	// ======================================================================
	// program window: page n covers 16n .. 16n+15, pages 6 and 7 absent
	wire       window_in_range = program_window_selector <= `LEPR_WINDOW_LAST;
	wire [6:0] window_location = {program_window_selector, prog_req_in.offset};

	// next program address word, registered whole; a window of six or
	// seven still yields a location, the range flag keeps it off the memory
	wire lepr_pkg::lepr_prog_addr_t next_prog_addr = '{
		valid:    prog_req_in.valid,
		in_range: window_in_range,
		location: window_location
	};

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			prog_addr_out <= '0;
		end else begin
			prog_addr_out <= next_prog_addr;
		end
	end

	// ======================================================================
	// engine start: first fetch location is the start register
	wire [2:0][6:0] next_fetch_location;

	// each engine takes its start location on its own start pulse
	assign next_fetch_location[0] = engine_start_in[0] ? engine_start_location[0] :
		engine_fetch_location_out[0];
	assign next_fetch_location[1] = engine_start_in[1] ? engine_start_location[1] :
		engine_fetch_location_out[1];
	assign next_fetch_location[2] = engine_start_in[2] ? engine_start_location[2] :
		engine_fetch_location_out[2];

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			engine_fetch_location_out <= '0;
			engine_fetch_valid_out    <= 3'h0;
		end else begin
			engine_fetch_location_out <= next_fetch_location;
			engine_fetch_valid_out    <= engine_start_in;
		end
	end

	// ======================================================================
	// LED levels: duty scaled by the group scaler, follows scaler writes
	wire [8:0][7:0] led_scale;
	wire [8:0][7:0] next_led_level;

	// scaler seen by each LED, picked by its group; a scaler still at its
	// reset value of zero holds its LEDs dark until software writes it
	assign led_scale[0] = group_scale(led_group_in[0], group_one_dim_scale,
		group_two_dim_scale, group_three_dim_scale);
	assign led_scale[1] = group_scale(led_group_in[1], group_one_dim_scale,
		group_two_dim_scale, group_three_dim_scale);
	assign led_scale[2] = group_scale(led_group_in[2], group_one_dim_scale,
		group_two_dim_scale, group_three_dim_scale);
	assign led_scale[3] = group_scale(led_group_in[3], group_one_dim_scale,
		group_two_dim_scale, group_three_dim_scale);
	assign led_scale[4] = group_scale(led_group_in[4], group_one_dim_scale,
		group_two_dim_scale, group_three_dim_scale);
	assign led_scale[5] = group_scale(led_group_in[5], group_one_dim_scale,
		group_two_dim_scale, group_three_dim_scale);
	assign led_scale[6] = group_scale(led_group_in[6], group_one_dim_scale,
		group_two_dim_scale, group_three_dim_scale);
	assign led_scale[7] = group_scale(led_group_in[7], group_one_dim_scale,
		group_two_dim_scale, group_three_dim_scale);
	assign led_scale[8] = group_scale(led_group_in[8], group_one_dim_scale,
		group_two_dim_scale, group_three_dim_scale);

	// scaled level of each LED, a whole group moves on one scaler write
	assign next_led_level[0] = scale_level(led_duty[0], led_scale[0]);
	assign next_led_level[1] = scale_level(led_duty[1], led_scale[1]);
	assign next_led_level[2] = scale_level(led_duty[2], led_scale[2]);
	assign next_led_level[3] = scale_level(led_duty[3], led_scale[3]);
	assign next_led_level[4] = scale_level(led_duty[4], led_scale[4]);
	assign next_led_level[5] = scale_level(led_duty[5], led_scale[5]);
	assign next_led_level[6] = scale_level(led_duty[6], led_scale[6]);
	assign next_led_level[7] = scale_level(led_duty[7], led_scale[7]);
	assign next_led_level[8] = scale_level(led_duty[8], led_scale[8]);

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			led_level_out <= '0;
		end else begin
			led_level_out <= next_led_level;
		end
	end

endmodule // lepr_regs

//--- lepr_regs_props.sv
/* port timing checks for the LED program register bank.
   assumes binding onto lepr_regs, one clock, reset active low. */
`timescale 1ns/1ps
module lepr_regs_props (
	input wire logic                      clk_in,
	input wire logic                      rstn_in,
	input wire lepr_pkg::lepr_reg_req_t   reg_req_in,
	input wire logic [7:0]                reg_rdata_out,
	input wire logic                      reg_rvalid_out,
	input wire lepr_pkg::lepr_prog_req_t  prog_req_in,
	input wire lepr_pkg::lepr_prog_addr_t prog_addr_out,
	input wire logic [2:0]                engine_start_in,
	input wire logic [2:0][6:0]           engine_fetch_location_out,
	input wire logic [2:0]                engine_fetch_valid_out
);
	// ==================================================================
	// register reads
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	sequence s_rd(a);
		reg_req_in.rd && reg_req_in.addr == a;
	endsequence
	a_read_answer: assert property (reg_req_in.rd |=> reg_rvalid_out)
		else $error("read not answered");
	a_no_stray_data: assert property (!reg_req_in.rd |=> !reg_rvalid_out && reg_rdata_out == 8'h00)
		else $error("read data without read");
	a_start_top_zero: assert property (s_rd(8'h4C) |=> !reg_rdata_out[7])
		else $error("start location bit 7 set");
	a_window_top_zero: assert property (s_rd(8'h4F) |=> reg_rdata_out[7:3] == 5'h00)
		else $error("window selector upper bits set");
	// ==================================================================
	// program window and engine start
	a_window_offset: assert property (prog_req_in.valid |=> prog_addr_out.valid
		&& prog_addr_out.location[3:0] == $past(prog_req_in.offset))
		else $error("program offset lost");
	a_range_flag: assert property (prog_req_in.valid |=>
		prog_addr_out.in_range == (prog_addr_out.location[6:4] < 3'h6))
		else $error("window range flag wrong");
	a_fetch_pulse: assert property (1'b1 |=> engine_fetch_valid_out == $past(engine_start_in))
		else $error("fetch pulse wrong");
	a_fetch_hold: assert property (engine_start_in == 3'h0 |=> $stable(engine_fetch_location_out))
		else $error("fetch location moved");
endmodule // lepr_regs_props

bind lepr_regs lepr_regs_props u_props (.clk_in, .rstn_in, .reg_req_in, .reg_rdata_out,
	.reg_rvalid_out, .prog_req_in, .prog_addr_out, .engine_start_in,
	.engine_fetch_location_out, .engine_fetch_valid_out);

//--- lepr_regs_test.sv
/* self-checking bench of the LED program register bank.
   assumes the checker is bound from its own file. */
`timescale 1ns/1ps
module lepr_regs_test;
	logic                      clk_in, rstn_in, engine_one_aux_output_assigned_in;
	lepr_pkg::lepr_reg_req_t   reg_req_in;
	logic [7:0]                reg_rdata_out;
	logic                      reg_rvalid_out;
	lepr_pkg::lepr_prog_req_t  prog_req_in;
	lepr_pkg::lepr_prog_addr_t prog_addr_out;
	logic [2:0]                engine_start_in, engine_fetch_valid_out;
	logic [2:0][6:0]           engine_fetch_location_out;
	logic [8:0][1:0]           led_group_in;
	logic [8:0][7:0]           led_level_out;
	logic [8:0]                engine_one_outputs_assigned_in;
	int                        fail_count, n_compared;
	logic [7:0] adr [9] = '{8'h48, 8'h49, 8'h4A, 8'h4C, 8'h4D, 8'h4E, 8'h4F, 8'h70, 8'h71};
	logic [7:0] msk [7] = '{8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'h7F, 8'h7F, 8'h07};

	lepr_regs dut (.clk_in, .rstn_in, .reg_req_in, .reg_rdata_out, .reg_rvalid_out,
		.prog_req_in, .prog_addr_out, .engine_start_in, .engine_fetch_location_out,
		.engine_fetch_valid_out, .led_group_in, .led_level_out,
		.engine_one_aux_output_assigned_in, .engine_one_outputs_assigned_in);

	// ==================================================================
	// helpers
	function automatic logic [7:0] scl(input logic [7:0] d, input logic [7:0] s);
		return 8'((16'(d) * s + d) >> 8);
	endfunction
	task chk(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		reg_req_in = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_in) #1;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		reg_req_in = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_in) #1;
		chk({7'h00, reg_rvalid_out}, 8'h01);
		chk(reg_rdata_out, e);
	endtask
	task idle(input int n);
		reg_req_in = '0;
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task test_done;
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ==================================================================
	// scenarios
	task t_regs;
		foreach (adr[i]) rd(adr[i], 8'h00);
		foreach (msk[i]) begin
			wr(adr[i], 8'hFF);
			rd(adr[i], msk[i]);
		end
		wr(8'h70, 8'hFF);
		wr(8'h71, 8'hFF);
		rd(8'h70, 8'h00);
		rd(8'h71, 8'h00);
		rd(8'h50, 8'h00);
		idle(1);
		$display("done: register access");
	endtask
	task t_window;
		for (int w = 0; w < 8; w++) begin
			wr(8'h4F, 8'(w));
			reg_req_in = '0;
			prog_req_in = '{valid: 1'b1, offset: 4'(15 - w)};
			@(posedge clk_in) #1;
			prog_req_in.valid = 1'b0;
			chk({1'b0, prog_addr_out.location}, 8'(w * 16 + 15 - w));
			chk({6'h00, prog_addr_out.valid, prog_addr_out.in_range}, {6'h00, 1'b1, w < 6});
		end
		$display("done: program window");
	endtask
	task t_start;
		wr(8'h4C, 8'h55);
		wr(8'h4D, 8'h2A);
		wr(8'h4E, 8'h7F);
		reg_req_in = '0;
		engine_start_in = 3'h7;
		@(posedge clk_in) #1;
		engine_start_in = 3'h0;
		chk({5'h00, engine_fetch_valid_out}, 8'h07);
		chk({1'b0, engine_fetch_location_out[0]}, 8'h55);
		chk({1'b0, engine_fetch_location_out[1]}, 8'h2A);
		chk({1'b0, engine_fetch_location_out[2]}, 8'h7F);
		$display("done: engine start");
	endtask
	task t_status(input logic a, input logic [8:0] o);
		engine_one_aux_output_assigned_in = a;
		engine_one_outputs_assigned_in = o;
		idle(2);
		rd(8'h70, {a, 6'h00, o[8]});
		rd(8'h71, o[7:0]);
		idle(1);
		$display("done: engine one assignment");
	endtask
	task t_fader;
		for (int i = 0; i < 9; i++) wr(8'h16 + 8'(i), (i == 8) ? 8'h10 : 8'h80);
		led_group_in = '0;
		led_group_in[0] = 2'h3;
		led_group_in[1] = 2'h3;
		led_group_in[3] = 2'h1;
		led_group_in[4] = 2'h2;
		wr(8'h49, 8'h80);
		wr(8'h4A, 8'h40);
		idle(2);
		chk(led_level_out[0], scl(8'h80, 8'h40));
		chk(led_level_out[1], scl(8'h80, 8'h40));
		chk(led_level_out[2], 8'h80);
		chk(led_level_out[8], 8'h10);
		chk(led_level_out[3], 8'h80);
		chk(led_level_out[4], scl(8'h80, 8'h80));
		wr(8'h48, 8'h00);
		idle(2);
		chk(led_level_out[3], 8'h00);
		$display("done: group dimming");
	endtask

	// ==================================================================
	// clock, watchdog and main sequence
	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end
	initial begin
		#20000;
		fail_count++;
		test_done;
	end
	initial begin
		rstn_in = 1'b0;
		reg_req_in = '0;
		prog_req_in = '0;
		engine_start_in = 3'h0;
		led_group_in = '0;
		engine_one_aux_output_assigned_in = 1'b0;
		engine_one_outputs_assigned_in = 9'h000;
		fail_count = 0;
		n_compared = 0;
		repeat (12) @(posedge clk_in);
		#1 rstn_in = 1'b1;
		t_regs;
		t_window;
		t_start;
		t_status(1'b1, 9'h1A5);
		t_status(1'b0, 9'h05A);
		t_fader;
		test_done;
	end
endmodule // lepr_regs_test
